// File: rtl/lpc_pkg.sv
package lpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses, one word each)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_WAKE_CTRL = 8'h08;
  localparam logic [7:0] OFS_WAKE_WIN = 8'h0c;
  localparam logic [7:0] OFS_WAKE_PSC = 8'h10;

  // power_control_reg fields
  localparam int CTRL_STBY_POS = 1;
  localparam int CTRL_MON_EN_POS = 4;
  localparam int CTRL_THR_LSB = 5;
  localparam int CTRL_THR_W = 3;
  // power_status_reg fields
  localparam int STAT_MON_FLAG_POS = 2;
  // periodic_wakeup control fields
  localparam int WAKE_EN_POS = 1;
  localparam int WIN_W = 6;
  localparam int PSC_W = 4;

  // reset values
  localparam logic [2:0] RST_THR = 3'h0;
  localparam logic RST_MON_EN = 1'b0;
  localparam logic RST_STBY = 1'b0;
  localparam logic RST_WAKE_EN = 1'b0;
  localparam logic [5:0] RST_WIN = 6'h3f;
  localparam logic [3:0] RST_PSC = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // timing: slow oscillator tick derived from the system clock
  localparam int CLK_HZ = 50000000;
  localparam int SLOW_OSC_HZ = 128000;
  localparam int SLOW_DIV = CLK_HZ / SLOW_OSC_HZ;
  localparam int PSC_CNT_W = 14;
  localparam logic [13:0] PSC_LONG_DIV = 14'h2800;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    LPC_RUN,
    LPC_EXIT_WAIT,
    LPC_FLASH_WAIT,
    LPC_SLEEP,
    LPC_STANDBY
  } lpc_mode_t;

  // core and event controller side requests
  typedef struct packed {
    logic wfi;
    logic wait_for_event_instr;
    logic deep_sleep_select;
    logic sleep_after_handler_exit;
    logic pending_wakes_event;
    logic irq_pending;
    logic irq_active;
    logic peripheral_pending_wake;
    logic event_wake;
    logic ext_event_wake;
    logic flash_busy;
  } lpc_core_t;

  // clock tree and power controls
  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic external_fast_osc_en;
    logic internal_fast_osc_en;
    logic pll_en;
    logic regulator_lp;
    logic io_hold;
    logic internal_slow_osc_en;
    logic independent_watchdog_en;
    logic sysclk_to_fast_osc;
  } lpc_clk_t;

endpackage

// File: rtl/lpc_power_ctrl.sv
// Contract
// - after reset the block is in run mode with no low-power state active.
// - sleep stops only the core clock; all peripheral clocks keep running.
// - sleep keeps pins as in run mode and peripheral clocks running.
// - wait instruction with deep sleep 0 and standby select 0 enters sleep.
// - sleep exits on interrupt after wfi, on wake event after wfe.
// - wait instruction with deep sleep 1 and standby select 1 enters standby.
// - standby stops fast oscillators, PLL, peripheral clocks; regulator low power.
// - standby holds SRAM, registers and pin states for resumption.
// - watchdog and slow oscillator keep running in standby.
// - standby entry waits while flash programming is busy.
// - standby wakes on auto-wakeup or event line, no reset, fast osc clock.
// - interrupt wake after wfi runs that interrupt's handler first.
// - event-mode lines wake a wfe state without interrupt controller setup.
// - with handler-exit option, enter low power after handlers all finish.
// - without handler-exit option, enter low power at once.
// - pending-wakes option lets any pending source wake a wfe state.
// - supply monitor output drives event line 8 edge trigger.
// - a readable flag shows supply above or below the threshold.
// - auto-wakeup counter periodically wakes standby without external interrupt.
// - auto-wakeup counts on the 128 kHz slow oscillator time base.
// - standby select picks standby at 1, sleep at 0; cleared on standby wake.
// - monitor flag is 1 below threshold, 0 above, valid only when enabled.
// - wake-up when auto-wakeup counter equals the 6-bit window value.
// - 4-bit prescaler divides time base; code 0 turns it off (here code 0 passes every tick, like code 1).
//
// The implementer's own choices: strobed register access and the address map.
module lpc_power_ctrl #(
  parameter int SLOW_DIV = lpc_pkg::SLOW_DIV
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [lpc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // core and event controller
  input wire lpc_pkg::lpc_core_t core_i,
  output logic service_irq_first_o,
  // analog supply comparator
  input wire logic supply_below_i,
  output logic [2:0] monitor_threshold_sel_o,
  output logic monitor_enable_o,
  output logic event_line8_o,
  // clock tree and power
  output lpc_pkg::lpc_clk_t clk_ctrl_o,
  output logic periodic_wakeup_o,
  output logic [2:0] mode_o
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    lpc_pkg::lpc_mode_t mode;
    logic entered_by_wfe;
    logic target_standby;
    logic [2:0] monitor_threshold_sel;
    logic monitor_enable;
    logic standby_select;
    logic wakeup_counter_enable;
    logic [5:0] wakeup_window_value;
    logic [3:0] wakeup_prescaler;
    logic mon_sync1;
    logic mon_sync2;
    logic [15:0] slow_cnt;
    logic [13:0] psc_cnt;
    logic [5:0] wake_cnt;
    logic wake_hit;
    logic service_irq_first;
    logic [31:0] rdata;
    lpc_pkg::lpc_clk_t clk;
  } lpc_reg_t;

  lpc_reg_t r;
  lpc_reg_t next_r;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler code to division ratio; codes 0 and 1 pass every tick
  // codes 14 and 15 share the longest division
  function automatic logic [13:0] psc_limit(input logic [3:0] code);
    logic [13:0] lim;
    lim = 14'h0001;
    if (code >= 4'he) begin
      lim = lpc_pkg::PSC_LONG_DIV;
    end else if (code >= 4'h2) begin
      lim = 14'h0001 << (code - 4'h1);
    end
    return lim;
  endfunction

  function automatic lpc_pkg::lpc_clk_t clk_for(input lpc_pkg::lpc_mode_t m);
    lpc_pkg::lpc_clk_t c;
    c = '{default: 1'b1};
    c.regulator_lp = 1'b0;
    c.io_hold = 1'b0;
    c.sysclk_to_fast_osc = 1'b0;
    case (m)
      lpc_pkg::LPC_SLEEP: begin
        c.core_clk_en = 1'b0;
      end
      lpc_pkg::LPC_STANDBY: begin
        c.core_clk_en = 1'b0;
        c.periph_clk_en = 1'b0;
        c.external_fast_osc_en = 1'b0;
        c.internal_fast_osc_en = 1'b0;
        c.pll_en = 1'b0;
        c.regulator_lp = 1'b1;
        c.io_hold = 1'b1;
      end
      default: begin
      end
    endcase
    // slow oscillator and watchdog stay on in every mode
    c.internal_slow_osc_en = 1'b1;
    c.independent_watchdog_en = 1'b1;
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic slow_tick;
  logic psc_tick;
  logic wait_req;
  logic wake_any;
  logic enter_now;
  logic stby_wake;
  logic pick_standby;
  logic [31:0] rd_word;

  always_comb begin
    next_r = r;
    slow_tick = 1'b0;
    psc_tick = 1'b0;
    wake_any = 1'b0;
    enter_now = 1'b0;
    stby_wake = 1'b0;
    pick_standby = 1'b0;
    rd_word = 32'h0000_0000;
    wait_req = core_i.wfi | core_i.wait_for_event_instr;
    next_r.service_irq_first = 1'b0;
    next_r.wake_hit = 1'b0;
    next_r.rdata = 32'h0000_0000;

    // register writes
    if (wr_i) begin
      case (addr_i)
        lpc_pkg::OFS_CTRL: begin
          next_r.monitor_threshold_sel =
            wdata_i[lpc_pkg::CTRL_THR_LSB +: lpc_pkg::CTRL_THR_W];
          next_r.monitor_enable = wdata_i[lpc_pkg::CTRL_MON_EN_POS];
          next_r.standby_select = wdata_i[lpc_pkg::CTRL_STBY_POS];
        end
        lpc_pkg::OFS_WAKE_CTRL: begin
          next_r.wakeup_counter_enable = wdata_i[lpc_pkg::WAKE_EN_POS];
        end
        lpc_pkg::OFS_WAKE_WIN: begin
          next_r.wakeup_window_value = wdata_i[lpc_pkg::WIN_W-1:0];
        end
        lpc_pkg::OFS_WAKE_PSC: begin
          next_r.wakeup_prescaler = wdata_i[lpc_pkg::PSC_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // register reads, answered in the next cycle only; unmapped reads zero
    // the bus never waits, so the read word is built from the current state
    case (addr_i)
      lpc_pkg::OFS_CTRL: begin
        rd_word[lpc_pkg::CTRL_THR_LSB +: lpc_pkg::CTRL_THR_W] = r.monitor_threshold_sel;
        rd_word[lpc_pkg::CTRL_MON_EN_POS] = r.monitor_enable;
        rd_word[lpc_pkg::CTRL_STBY_POS] = r.standby_select;
      end
      lpc_pkg::OFS_STATUS: begin
        rd_word[lpc_pkg::STAT_MON_FLAG_POS] = r.monitor_enable & r.mon_sync2;
      end
      lpc_pkg::OFS_WAKE_CTRL: begin
        rd_word[lpc_pkg::WAKE_EN_POS] = r.wakeup_counter_enable;
      end
      lpc_pkg::OFS_WAKE_WIN: begin
        rd_word[lpc_pkg::WIN_W-1:0] = r.wakeup_window_value;
      end
      lpc_pkg::OFS_WAKE_PSC: begin
        rd_word[lpc_pkg::PSC_W-1:0] = r.wakeup_prescaler;
      end
      default: begin
      end
    endcase
    if (rd_i) begin
      next_r.rdata = rd_word;
    end

    ////////////////////////////////////////////////////////////////////////
    // supply monitor: comparator is asynchronous, so two flops first
    // this costs two cycles of delay on the flag and three on line 8
    next_r.mon_sync1 = supply_below_i;
    next_r.mon_sync2 = r.mon_sync1;

    ////////////////////////////////////////////////////////////////////////
    // slow oscillator time base as an enable pulse from the system clock
    // a small SLOW_DIV shortens every period in simulation
    if (r.slow_cnt >= 16'(SLOW_DIV - 1)) begin
      next_r.slow_cnt = 16'h0000;
      slow_tick = 1'b1;
    end else begin
      next_r.slow_cnt = r.slow_cnt + 16'h0001;
    end

    // prescaler and window counter
    if (!r.wakeup_counter_enable) begin
      next_r.psc_cnt = 14'h0000;
      next_r.wake_cnt = 6'h00;
    end else begin
      if (slow_tick) begin
        if (r.psc_cnt >= psc_limit(r.wakeup_prescaler) - 14'h0001) begin
          next_r.psc_cnt = 14'h0000;
          psc_tick = 1'b1;
        end else begin
          next_r.psc_cnt = r.psc_cnt + 14'h0001;
        end
      end
      if (psc_tick) begin
        if (r.wake_cnt == r.wakeup_window_value) begin
          next_r.wake_cnt = 6'h00;
          next_r.wake_hit = 1'b1;
        end else begin
          next_r.wake_cnt = r.wake_cnt + 6'h01;
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake sources seen by the current low-power state
    if (r.entered_by_wfe) begin
      wake_any = core_i.event_wake | core_i.irq_pending;
      if (core_i.pending_wakes_event) begin
        wake_any = wake_any | core_i.peripheral_pending_wake;
      end
    end else begin
      wake_any = core_i.irq_pending;
    end
    // standby also listens to the event controller and the periodic counter
    stby_wake = wake_any | core_i.ext_event_wake | r.wake_hit;

    case (r.mode)
      lpc_pkg::LPC_RUN: begin
        if (wait_req) begin
          next_r.entered_by_wfe = core_i.wait_for_event_instr;
          // standby only when both selects are set
          next_r.target_standby = core_i.deep_sleep_select & r.standby_select;
          if (core_i.sleep_after_handler_exit && core_i.irq_active) begin
            next_r.mode = lpc_pkg::LPC_EXIT_WAIT;
          end else begin
            enter_now = 1'b1;
          end
        end
      end
      lpc_pkg::LPC_EXIT_WAIT: begin
        // handlers still in service finish before the stop
        if (!core_i.irq_active) begin
          enter_now = 1'b1;
        end
      end
      lpc_pkg::LPC_FLASH_WAIT: begin
        // programming must finish before the regulator drops
        if (!core_i.flash_busy) begin
          next_r.mode = lpc_pkg::LPC_STANDBY;
        end
      end
      lpc_pkg::LPC_SLEEP: begin
        // a wfi wake by interrupt tells the core to run the handler first
        if (wake_any) begin
          next_r.mode = lpc_pkg::LPC_RUN;
          next_r.service_irq_first = ~r.entered_by_wfe & core_i.irq_pending;
        end
      end
      lpc_pkg::LPC_STANDBY: begin
        if (stby_wake) begin
          next_r.mode = lpc_pkg::LPC_RUN;
          next_r.standby_select = 1'b0;
          next_r.service_irq_first = ~r.entered_by_wfe & core_i.irq_pending;
        end
      end
      default: begin
        next_r.mode = lpc_pkg::LPC_RUN;
      end
    endcase

    // a wait in run mode uses the live selects; a deferred one the latched choice
    if (r.mode == lpc_pkg::LPC_RUN) begin
      pick_standby = core_i.deep_sleep_select & r.standby_select;
    end else begin
      pick_standby = r.target_standby;
    end
    if (enter_now) begin
      if (pick_standby) begin
        next_r.mode = core_i.flash_busy ? lpc_pkg::LPC_FLASH_WAIT
                                        : lpc_pkg::LPC_STANDBY;
      end else begin
        next_r.mode = lpc_pkg::LPC_SLEEP;
      end
    end

    next_r.clk = clk_for(next_r.mode);
    // fast oscillator becomes the system clock on every standby wake
    next_r.clk.sysclk_to_fast_osc =
      (r.mode == lpc_pkg::LPC_STANDBY) && (next_r.mode == lpc_pkg::LPC_RUN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // one register for all state but line8_q keeps reset and update in one place
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r.mode <= lpc_pkg::LPC_RUN;
      r.entered_by_wfe <= 1'b0;
      r.target_standby <= 1'b0;
      r.monitor_threshold_sel <= lpc_pkg::RST_THR;
      r.monitor_enable <= lpc_pkg::RST_MON_EN;
      r.standby_select <= lpc_pkg::RST_STBY;
      r.wakeup_counter_enable <= lpc_pkg::RST_WAKE_EN;
      r.wakeup_window_value <= lpc_pkg::RST_WIN;
      r.wakeup_prescaler <= lpc_pkg::RST_PSC;
      r.mon_sync1 <= 1'b0;
      r.mon_sync2 <= 1'b0;
      r.slow_cnt <= 16'h0000;
      r.psc_cnt <= 14'h0000;
      r.wake_cnt <= 6'h00;
      r.wake_hit <= 1'b0;
      r.service_irq_first <= 1'b0;
      r.rdata <= 32'h0000_0000;
      // every clock permit open, so the core runs from the first edge
      r.clk.core_clk_en <= 1'b1;
      r.clk.periph_clk_en <= 1'b1;
      r.clk.external_fast_osc_en <= 1'b1;
      r.clk.internal_fast_osc_en <= 1'b1;
      r.clk.pll_en <= 1'b1;
      r.clk.regulator_lp <= 1'b0;
      r.clk.io_hold <= 1'b0;
      r.clk.internal_slow_osc_en <= 1'b1;
      r.clk.independent_watchdog_en <= 1'b1;
      r.clk.sysclk_to_fast_osc <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line 8 sees only the synchronised level, gated by the enable
  // the enable comes from next_r so line 8 drops on the same edge that
  // clears the enable, never one cycle late
  logic line8_q;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line8_q <= 1'b0;
    end else begin
      line8_q <= next_r.monitor_enable & r.mon_sync2;
    end
  end

  assign rdata_o = r.rdata;
  assign service_irq_first_o = r.service_irq_first;
  assign monitor_threshold_sel_o = r.monitor_threshold_sel;
  assign monitor_enable_o = r.monitor_enable;
  assign event_line8_o = line8_q;
  assign clk_ctrl_o = r.clk;
  assign periodic_wakeup_o = r.wake_hit;
  assign mode_o = r.mode;

endmodule

// File: test/low_power_mode_controller_bench.sv
module low_power_mode_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, rst_n_i, wr_i, rd_i, supply_below_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  lpc_pkg::lpc_core_t cmd, core;
  lpc_pkg::lpc_clk_t clk_ctrl;
  logic irq_first, line8, mon_en, pwake;
  logic [2:0] thr, mode;
  int seed = 9425;
  int miscompares = 0;
  int samples_checked = 0;
  int regm [5];
  int maskm [5] = '{32'hf2, 32'h0, 32'h2, 32'h3f, 32'hf};

  lpc_power_ctrl #(.SLOW_DIV(4)) uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .core_i(core),
    .service_irq_first_o(irq_first), .supply_below_i(supply_below_i),
    .monitor_threshold_sel_o(thr), .monitor_enable_o(mon_en), .event_line8_o(line8),
    .clk_ctrl_o(clk_ctrl), .periodic_wakeup_o(pwake), .mode_o(mode));
  lpc_core_model partner (.clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .mode_i(mode),
    .core_o(core));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test(input int timed_out);
    miscompares += timed_out;
    $display("compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pwr(input logic [12:0] got, input logic [12:0] exp);
    chk_reg({19'h0, got}, {19'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
    if (a[7:2] < 5) regm[a[7:2]] = d & maskm[a[7:2]];
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk_reg(rdata_o, e);
  endtask
  task automatic issue(input lpc_pkg::lpc_core_t c);
    @(posedge clock_i);
    cmd <= c;
    @(posedge clock_i);
    c.wfi = 1'b0;
    c.wait_for_event_instr = 1'b0;
    cmd <= c;
    #1;
  endtask
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    while (mode !== m && n < 200) begin
      @(posedge clock_i);
      #1 n++;
    end
    if (n == 200) stop_test(1);
  endtask
  // counts clock edges up to the next wake pulse, 400 meaning none came
  task automatic wait_pulse(output int c);
    c = 0;
    do begin
      @(posedge clock_i);
      #1 c++;
    end while (pwake !== 1'b1 && c < 400);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  initial begin
    int i, n, w;
    lpc_pkg::lpc_core_t c;
    rst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h0;
    wdata_i = 32'h0;
    supply_below_i = 1'b0;
    cmd = '0;
    regm = '{0, 0, 0, 32'h3f, 0};
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1 chk_pwr({mode, clk_ctrl}, {3'h0, 10'h3e6});
    for (i = 0; i < 5; i++) rd(8'(i * 4), regm[i]);
    for (i = 0; i < 5; i++) begin
      wr(8'(i * 4), 32'hffffffff);
      rd(8'(i * 4), regm[i]);
    end
    rd(8'h14, 32'h0);
    // monitor: threshold and enable in one write, enable on odd passes, supply level random
    for (i = 0; i < 8; i++) begin
      w = $random(seed);
      wr(8'h0, {24'h0, w[7:5], i[0], 4'h0});
      supply_below_i <= w[8];
      repeat (4) @(posedge clock_i);
      rd(8'h04, {29'h0, w[8] & i[0], 2'h0});
      chk_reg({31'h0, line8}, {31'h0, w[8] & i[0]});
      chk_reg({29'h0, thr}, {29'h0, w[7:5]});
    end
    // i[0] wait-for-event, i[1] deep sleep, i[2] standby select
    for (i = 0; i < 8; i++) begin
      wr(8'h0, {30'h0, i[2], 1'b0});
      c = '0;
      c.wfi = !i[0];
      c.wait_for_event_instr = i[0];
      c.deep_sleep_select = i[1];
      c.irq_pending = !i[0];
      c.event_wake = i[0] && i != 1 && i != 7;
      c.ext_event_wake = i == 7;
      c.pending_wakes_event = i == 1;
      c.peripheral_pending_wake = i == 1;
      issue(c);
      chk_pwr({mode, clk_ctrl}, (i[1] & i[2]) ? {3'h4, 10'h01e} : {3'h3, 10'h1e6});
      wait_mode(3'h0);
      chk_reg({30'h0, irq_first, clk_ctrl.sysclk_to_fast_osc}, {30'h0, !i[0], i[1] & i[2]});
      if (i[1] & i[2]) regm[0] = 0;
      rd(8'h0, regm[0]);
    end
    // auto-wakeup period over window and prescaler codes
    for (i = 0; i < 4; i++) begin
      w = ($random(seed) & 3) + 1;
      wr(8'h08, 32'h0);
      wr(8'h10, i);
      wr(8'h0c, w);
      wr(8'h08, 32'h2);
      wait_pulse(n);
      wait_pulse(n);
      wait_pulse(n);
      chk_reg(n, (w + 1) * 4 * ((i < 2) ? 1 : 1 << (i - 1)));
    end
    // handler-exit wait, then flash wait, then standby left by the counter
    wr(8'h0, 32'h2);
    c = '0;
    c.wfi = 1'b1;
    c.deep_sleep_select = 1'b1;
    c.sleep_after_handler_exit = 1'b1;
    c.irq_active = 1'b1;
    c.flash_busy = 1'b1;
    issue(c);
    repeat (3) @(posedge clock_i);
    #1 chk_reg({29'h0, mode}, 32'h1);
    c.wfi = 1'b0;
    c.irq_active = 1'b0;
    cmd <= c;
    wait_mode(3'h2);
    repeat (3) @(posedge clock_i);
    #1 chk_reg({29'h0, mode}, 32'h2);
    c.flash_busy = 1'b0;
    cmd <= c;
    wait_mode(3'h4);
    wait_mode(3'h0);
    chk_reg({31'h0, clk_ctrl.sysclk_to_fast_osc}, 32'h1);
    rd(8'h0, 32'h0);
    wr(8'h08, 32'h0);
    wait_pulse(n);
    chk_reg(n, 400);
    stop_test(0);
  end
endmodule

// File: test/lpc_core_model.sv
module lpc_core_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // bench commands and block state
  input wire lpc_pkg::lpc_core_t cmd_i,
  input wire logic [2:0] mode_i,
  // toward the block
  output lpc_pkg::lpc_core_t core_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] lp_cnt;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)
      lp_cnt <= 4'h0;
    else if (mode_i < 3'h3)
      lp_cnt <= 4'h0;
    else if (lp_cnt != 4'hf)
      lp_cnt <= lp_cnt + 4'h1;
  end

  // wake sources appear only after a stay in low power, so the stop is seen first
  always_comb begin
    core_o = cmd_i;
    if (lp_cnt < 4'h4) begin
      core_o.irq_pending = 1'b0;
      core_o.event_wake = 1'b0;
      core_o.ext_event_wake = 1'b0;
      core_o.peripheral_pending_wake = 1'b0;
    end
  end
endmodule

// File: test/lpc_power_ctrl_sva.sv
module lpc_power_ctrl_sva #(
  parameter int SLOW_DIV = 390
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // watched ports
  input wire lpc_pkg::lpc_core_t core_i,
  input wire logic monitor_enable_o,
  input wire logic event_line8_o,
  input wire lpc_pkg::lpc_clk_t clk_ctrl_o,
  input wire logic [2:0] mode_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  wire logic instr = core_i.wfi | core_i.wait_for_event_instr;

  sequence quick_sleep_s;
    mode_o == 3'h0 && instr && !core_i.deep_sleep_select && !core_i.sleep_after_handler_exit;
  endsequence
  sequence stby_wake_s;
    mode_o == 3'h4 ##1 mode_o == 3'h0;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  run_after_reset_a: assert property ($rose(rst_n_i) |-> mode_o == 3'h0)
    else $error("not in run mode after reset");
  sleep_entry_a: assert property (quick_sleep_s |=> mode_o == 3'h3)
    else $error("sleep not entered at once");
  sleep_clocks_a: assert property (mode_o == 3'h3 |-> clk_ctrl_o == 10'h1e6)
    else $error("sleep clock controls wrong");
  standby_clocks_a: assert property (mode_o == 3'h4 |-> clk_ctrl_o == 10'h01e)
    else $error("standby clock controls wrong");
  slow_osc_a: assert property (clk_ctrl_o.internal_slow_osc_en && clk_ctrl_o.independent_watchdog_en)
    else $error("slow oscillator or watchdog stopped");
  flash_hold_a: assert property (mode_o == 3'h2 && core_i.flash_busy |=> mode_o == 3'h2)
    else $error("standby entered during flash work");
  exit_hold_a: assert property (mode_o == 3'h1 && core_i.irq_active |=> mode_o == 3'h1)
    else $error("left handler wait too early");
  wfi_wake_a: assert property (mode_o == 3'h3 && core_i.irq_pending |=> mode_o == 3'h0)
    else $error("sleep not left on interrupt");
  standby_fast_a: assert property (stby_wake_s |-> clk_ctrl_o.sysclk_to_fast_osc)
    else $error("no switch to fast oscillator");
  monitor_off_a: assert property (!monitor_enable_o [*3] |-> !event_line8_o)
    else $error("line 8 active with monitor off");
endmodule

bind lpc_power_ctrl lpc_power_ctrl_sva #(.SLOW_DIV(SLOW_DIV)) sva (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .core_i(core_i), .monitor_enable_o(monitor_enable_o),
  .event_line8_o(event_line8_o), .clk_ctrl_o(clk_ctrl_o), .mode_o(mode_o));
